// *** verilog/uif_pkg.sv ***
// Purpose: constants for the usb interrupt flag and enable block
// Assumes: 20 MHz module clock, 32-bit register words
// Notes:   offsets are byte addresses on the register bus
package uif_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OTG_FLAGS_OFS = 8'h00;
    localparam logic [7:0] OTG_MASK_OFS  = 8'h04;
    localparam logic [7:0] USB_FLAGS_OFS = 8'h08;
    localparam logic [7:0] USB_MASK_OFS  = 8'h0c;
    localparam logic [7:0] CTRL_OFS      = 8'h10;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int OTG_ID_B      = 7;
    localparam int OTG_MS_B      = 6;
    localparam int OTG_LINE_B    = 5;
    localparam int OTG_ACT_B     = 4;
    localparam int OTG_SESSV_B   = 3;
    localparam int OTG_BSEND_B   = 2;
    localparam int OTG_AVBUS_B   = 0;
    localparam int USB_STALL_B   = 7;
    localparam int USB_ATTACH_B  = 6;
    localparam int USB_RESUME_B  = 5;
    localparam int USB_IDLE_B    = 4;
    localparam int USB_TOKEN_B   = 3;
    localparam int USB_SOF_B     = 2;
    localparam int USB_ERR_B     = 1;
    localparam int USB_RSTDET_B  = 0;
    localparam int CTRL_HOST_B   = 0;
    localparam int CTRL_LOWSPD_B = 1;
    localparam logic [7:0] OTG_IMPL_MASK = 8'hfd;
    localparam logic [7:0] DEV_READ_MASK = 8'hbf;
    localparam logic [7:0] USB_W1C_MASK  = 8'hfd;
    localparam logic [7:0] CTRL_MASK     = 8'h03;
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int K_STATE_NS     = 2500;
    localparam int IDLE_US        = 3000;
    localparam int LINE_STABLE_US = 1000;
    localparam int CLK_MHZ        = 20;
    localparam int T25_CYC        = (K_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CYC       = IDLE_US * CLK_MHZ;
    localparam int MS_CYC         = LINE_STABLE_US * CLK_MHZ;
endpackage : uif_pkg

// *** verilog/uif_hold_timer.sv ***
// Purpose: pulse once when a condition has held for a set number of cycles
// Assumes: cond_i synchronous to clk_i
// Notes:   one pulse per unbroken episode; the condition must drop to re-arm
`timescale 1ns/100ps
`default_nettype none
module uif_hold_timer #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned LIMIT = 50
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // condition and result
    input  wire logic             cond_i,
    output logic                  hit_o,
    output logic [CNT_W-1:0]      cnt_o
);
    localparam logic [CNT_W-1:0] LIM_C = CNT_W'(LIMIT);
    localparam logic [CNT_W-1:0] LIM_M = CNT_W'(LIMIT - 1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_o <= '0;
            hit_o <= 1'b0;
        end else if (ce_i) begin
            // saturating count keeps a long episode from re-firing
            if (!cond_i) begin
                cnt_o <= '0;
            end else if (cnt_o != LIM_C) begin
                cnt_o <= cnt_o + 1'b1;
            end
            hit_o <= cond_i && (cnt_o == LIM_M);
        end
    end
endmodule : uif_hold_timer
`default_nettype wire

// *** verilog/uif_usb_irq.sv ***
// Purpose: usb otg interrupt flags, enables and request, on an axi4-lite slave
// Assumes: all inputs synchronous to mclk_i; ce_i low freezes every state
// Notes:   flag registers are write-one-to-clear; error summary follows its input
// Notes on behaviour
// RULE1: otg mask holds seven enables at bits 7..2 and 0.
// RULE2: otg mask and otg flags only act in host mode.
// RULE3: bits 15..8 read zero; otg mask bit 1 and device bit 6 too.
// RULE4: hardware sets flags; writing one clears, writing zero keeps.
// RULE5: software clears flags with whole-word writes of ones only.
// RULE6: device stall flag sets when a stall handshake is sent.
// RULE7: resume flag sets after a k-state lasts 2.5 us.
// RULE8: idle flag sets after 3 ms of continuous idle.
// RULE9: token done flag sets when token processing finishes.
// RULE10: clearing token done flag advances the transfer status fifo.
// RULE11: frame start flag sets on sof token or host threshold.
// RULE12: error summary is read-only, driven by enabled error conditions.
// RULE13: device bus reset flag after 2.5 us reset, once per reset.
// RULE14: host attach flag: no se0, no activity for 2.5 us.
// RULE15: host detach flag at bit 0, once per se0 episode.
// RULE16: mask bit 0 enables bus reset or detach by mode.
// RULE17: attach enable reads zero in device mode.
// RULE18: each usb mask bit lets the same flag raise the request.
// RULE19: line-state flag: stable 1 ms and differs from last recorded.
// RULE20: vbus flags set on crossings in either direction.
// RULE21: request high while any enabled flag is set.
// RULE22: reset clears all flags and enables.
`timescale 1ns/100ps
`default_nettype none
module uif_usb_irq #(
    parameter int unsigned IDLE_CYCLES = uif_pkg::IDLE_CYC,
    parameter int unsigned MS_CYCLES   = uif_pkg::MS_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // line monitor
    input  wire logic        dplus_i,
    input  wire logic        dminus_i,
    input  wire logic        bus_activity_i,
    input  wire logic        id_i,
    input  wire logic        session_valid_i,
    input  wire logic        b_session_end_i,
    input  wire logic        a_vbus_valid_i,
    // token engine and error detector
    input  wire logic        stall_sent_i,
    input  wire logic        token_done_i,
    input  wire logic        frame_start_i,
    input  wire logic        unmasked_error_i,
    // outputs
    output logic             stat_advance_o,
    output logic             irq_o
);
    import uif_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]  otg_flags_r;
    logic [7:0]  otg_mask_r;
    logic [7:0]  usb_flags_r;
    logic [7:0]  usb_mask_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_full_r;
    logic        w_full_r;
    logic [4:0]  mon_r;
    logic [1:0]  lstate_r;
    logic [1:0]  lstate_rec_r;
    logic [31:0] ms_cnt_r;
    logic        host;
    logic        se0;
    logic        kstate;
    logic        jstate;
    logic [1:0]  lstate;
    logic        wr_do;
    logic [7:0]  wr_byte;
    logic [7:0]  otg_set;
    logic [7:0]  usb_set;
    logic [7:0]  otg_clr;
    logic [7:0]  usb_clr;
    logic [7:0]  usb_flags_vis;
    logic [7:0]  usb_mask_vis;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        t25_k_hit;
    logic        t25_se0_hit;
    logic        t25_att_hit;
    logic        idle_hit;
    logic        line_hit;
    logic [15:0] se0_cnt;

    assign host    = ctrl_r[CTRL_HOST_B];
    assign se0     = !dplus_i && !dminus_i;
    // k is differential one at low speed, differential zero at full speed
    assign kstate  = ctrl_r[CTRL_LOWSPD_B] ? (dplus_i && !dminus_i) : (!dplus_i && dminus_i);
    assign jstate  = ctrl_r[CTRL_LOWSPD_B] ? (!dplus_i && dminus_i) : (dplus_i && !dminus_i);
    assign lstate  = {se0, jstate};
    assign wr_do   = aw_full_r && w_full_r && !s_axi_bvalid;
    assign wr_byte = w_strb_r[0] ? w_data_r[7:0] : 8'h00;

    function automatic logic is_wr(input logic [7:0] ofs);
        is_wr = wr_do && (aw_addr_r == ofs) && w_strb_r[0];
    endfunction : is_wr

    // ----------------------------------------
    // duration detectors
    // ----------------------------------------
    uif_hold_timer #(.CNT_W(16), .LIMIT(T25_CYC)) u_k_timer (
        .clk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cond_i(kstate), .hit_o(t25_k_hit), .cnt_o()
    );
    uif_hold_timer #(.CNT_W(16), .LIMIT(T25_CYC)) u_se0_timer (
        .clk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cond_i(se0), .hit_o(t25_se0_hit), .cnt_o(se0_cnt)
    );
    uif_hold_timer #(.CNT_W(16), .LIMIT(T25_CYC)) u_att_timer (
        .clk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cond_i(!se0 && !bus_activity_i), .hit_o(t25_att_hit), .cnt_o()
    );
    uif_hold_timer #(.CNT_W(32), .LIMIT(IDLE_CYCLES)) u_idle_timer (
        .clk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cond_i(jstate), .hit_o(idle_hit), .cnt_o()
    );
    // a one-cycle change of line state restarts the stability count
    uif_hold_timer #(.CNT_W(32), .LIMIT(MS_CYCLES)) u_line_timer (
        .clk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .cond_i(lstate == lstate_r), .hit_o(line_hit), .cnt_o()
    );

    // ----------------------------------------
    // monitor history and 1 ms tick
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mon_r        <= 5'h00;
            lstate_r     <= 2'h0;
            lstate_rec_r <= 2'h0;
            ms_cnt_r     <= 32'h0;
        end else if (ce_i) begin
            mon_r    <= {id_i, session_valid_i, b_session_end_i, a_vbus_valid_i, 1'b0};
            lstate_r <= lstate;
            if (line_hit) begin
                lstate_rec_r <= lstate_r;
            end
            if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
                ms_cnt_r <= 32'h0;
            end else begin
                ms_cnt_r <= ms_cnt_r + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // flag set and clear terms
    // ----------------------------------------
    always_comb begin
        otg_set = 8'h00;
        usb_set = 8'h00;
        // RULE2: otg events only in host
        if (host) begin
            // RULE20: either direction crossing
            otg_set[OTG_ID_B]    = id_i != mon_r[4];
            otg_set[OTG_SESSV_B] = session_valid_i != mon_r[3];
            otg_set[OTG_BSEND_B] = b_session_end_i != mon_r[2];
            otg_set[OTG_AVBUS_B] = a_vbus_valid_i != mon_r[1];
            otg_set[OTG_MS_B]    = ms_cnt_r == 32'(MS_CYCLES - 1);
            otg_set[OTG_ACT_B]   = bus_activity_i;
            // RULE19: stable and different
            otg_set[OTG_LINE_B]  = line_hit && (lstate_r != lstate_rec_r);
        end
        // RULE6: stall handshake sent
        usb_set[USB_STALL_B]  = stall_sent_i;
        // RULE14: attach in host only
        usb_set[USB_ATTACH_B] = host && t25_att_hit;
        // RULE7: k-state for 2.5 us
        usb_set[USB_RESUME_B] = t25_k_hit;
        // RULE8: idle for 3 ms
        usb_set[USB_IDLE_B]   = idle_hit;
        // RULE9: token processing done
        usb_set[USB_TOKEN_B]  = token_done_i;
        // RULE11: sof token or threshold
        usb_set[USB_SOF_B]    = frame_start_i;
        // RULE13 RULE15: reset or detach once per se0
        usb_set[USB_RSTDET_B] = t25_se0_hit;
        // RULE4 RULE5: ones in the written word clear
        otg_clr = is_wr(OTG_FLAGS_OFS) ? (wr_byte & OTG_IMPL_MASK) : 8'h00;
        usb_clr = is_wr(USB_FLAGS_OFS) ? (wr_byte & USB_W1C_MASK) : 8'h00;
    end

    // ----------------------------------------
    // flag registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        // RULE22: all cleared by reset
        if (!rst_n_i) begin
            otg_flags_r <= REG_RESET;
            usb_flags_r <= REG_RESET;
        end else if (ce_i) begin
            // RULE4: set wins over clear
            otg_flags_r <= ((otg_flags_r & ~otg_clr) | otg_set) & OTG_IMPL_MASK;
            usb_flags_r[7:2] <= (usb_flags_r[7:2] & ~usb_clr[7:2]) | usb_set[7:2];
            usb_flags_r[0]   <= (usb_flags_r[0] & ~usb_clr[0]) | usb_set[0];
            // RULE12: read-only error summary
            usb_flags_r[USB_ERR_B] <= unmasked_error_i;
        end
    end

    // ----------------------------------------
    // enable and control registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            otg_mask_r <= REG_RESET;
            usb_mask_r <= REG_RESET;
            ctrl_r     <= REG_RESET;
        end else if (ce_i) begin
            // RULE1: seven otg enables
            if (is_wr(OTG_MASK_OFS)) begin
                otg_mask_r <= wr_byte & OTG_IMPL_MASK;
            end
            if (is_wr(USB_MASK_OFS)) begin
                usb_mask_r <= wr_byte;
            end
            if (is_wr(CTRL_OFS)) begin
                ctrl_r <= wr_byte & CTRL_MASK;
            end
        end
    end

    // RULE17: attach enable hidden in device mode
    assign usb_flags_vis = host ? usb_flags_r : (usb_flags_r & DEV_READ_MASK);
    assign usb_mask_vis  = host ? usb_mask_r : (usb_mask_r & DEV_READ_MASK);

    // ----------------------------------------
    // request and fifo advance
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_o          <= 1'b0;
            stat_advance_o <= 1'b0;
        end else if (ce_i) begin
            // RULE18 RULE16 RULE21: same-position gating
            irq_o <= |(usb_flags_vis & usb_mask_vis) || (host && |(otg_flags_r & otg_mask_r));
            // RULE10: clearing token done pops the fifo
            stat_advance_o <= usb_clr[USB_TOKEN_B] && usb_flags_r[USB_TOKEN_B];
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        // RULE3: upper bits and holes read zero
        unique case (s_axi_araddr)
            OTG_FLAGS_OFS: rd_word[7:0] = otg_flags_r;
            OTG_MASK_OFS:  rd_word[7:0] = otg_mask_r;
            USB_FLAGS_OFS: rd_word[7:0] = usb_flags_vis;
            USB_MASK_OFS:  rd_word[7:0] = usb_mask_vis;
            CTRL_OFS:      rd_word[7:0] = ctrl_r;
            default:       rd_hit       = 1'b0;
        endcase
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                aw_full_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                w_full_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r inside {OTG_FLAGS_OFS, OTG_MASK_OFS, USB_FLAGS_OFS,
                                 USB_MASK_OFS, CTRL_OFS}) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_full_r     <= 1'b0;
                w_full_r      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_token_clear;
        ce_i && is_wr(USB_FLAGS_OFS) && wr_byte[USB_TOKEN_B] && usb_flags_r[USB_TOKEN_B];
    endsequence

    sequence s_advance_pulse;
        stat_advance_o ##1 !stat_advance_o || !ce_i;
    endsequence

    a_token_pop: assert property ( // RULE10
        @(posedge mclk_i) disable iff (!rst_n_i) s_token_clear |=> s_advance_pulse)
        else $error("token clear did not advance the status fifo");

    a_set_wins: assert property ( // RULE4
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && stall_sent_i && usb_clr[USB_STALL_B]) |=> usb_flags_r[USB_STALL_B])
        else $error("stall event lost under a clear");

    a_w1c_clear: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && usb_clr[USB_IDLE_B] && !usb_set[USB_IDLE_B]) |=> !usb_flags_r[USB_IDLE_B])
        else $error("idle flag not cleared by a written one");

    a_err_follow: assert property ( // RULE12
        @(posedge mclk_i) disable iff (!rst_n_i)
        ce_i |=> usb_flags_r[USB_ERR_B] == $past(unmasked_error_i))
        else $error("error summary does not follow its condition");

    a_reset_time: assert property ( // RULE13
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && t25_se0_hit && !host) |=> usb_flags_r[USB_RSTDET_B])
        else $error("bus reset flag missing after se0 run");

    a_se0_count: assert property ( // RULE15
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(t25_se0_hit) |-> $past(se0_cnt) == 16'(T25_CYC - 1))
        else $error("se0 detector fired at the wrong count");

    a_otg_host_only: assert property ( // RULE2
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && !host) |=> (otg_flags_r & ~$past(otg_flags_r)) == 8'h00)
        else $error("otg flag rose outside host mode");

    a_irq_gate: assert property ( // RULE21
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && host && (usb_flags_r & usb_mask_r) != 8'h00) |=> irq_o)
        else $error("request low with an enabled flag set");

    a_rd_reserved: assert property ( // RULE3
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("reserved read bits not zero");

    a_dev_attach: assert property ( // RULE17
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && !host && s_axi_arvalid && s_axi_arready && s_axi_araddr == USB_MASK_OFS)
        |=> !s_axi_rdata[USB_ATTACH_B])
        else $error("attach enable visible in device mode");
endmodule : uif_usb_irq
`default_nettype wire

// *** dv/test_uif_usb_irq.sv ***
// Purpose: random and corner checks of the usb flag and enable block
// Assumes: short timer parameters; device mode, full speed after reset
// Notes:   only mismatches and the verdict are printed
`timescale 1ns/100ps
`default_nettype none
module test_uif_usb_irq;
    import uif_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, d;
    logic [3:0]  s_axi_wstrb = 4'hf, ev = 4'h0, otg_in = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        dplus_i = 1'b0, dminus_i = 1'b0, unmasked_error_i = 1'b0, stat_advance_o, irq_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          mismatches = 0, check_count = 0, adv = 0, n, seed = 32'he803;
    int          pos[4] = '{OTG_AVBUS_B, OTG_BSEND_B, OTG_SESSV_B, OTG_ID_B};

    uif_usb_irq #(.IDLE_CYCLES(20), .MS_CYCLES(16)) dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .dplus_i(dplus_i), .dminus_i(dminus_i), .bus_activity_i(ev[0]), .id_i(otg_in[3]),
        .session_valid_i(otg_in[2]), .b_session_end_i(otg_in[1]), .a_vbus_valid_i(otg_in[0]),
        .stall_sent_i(ev[3]), .token_done_i(ev[2]), .frame_start_i(ev[1]),
        .unmasked_error_i(unmasked_error_i), .stat_advance_o(stat_advance_o), .irq_o(irq_o));

    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (stat_advance_o === 1'b1) adv <= adv + 1;

    // ----------------------------------------
    // bus and checking tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge mclk_i);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk_i); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task rdr(input logic [7:0] a);
        @(posedge mclk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk_i); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr

    task pulse(input int i);
        @(posedge mclk_i);
        ev[i] <= 1'b1;
        @(posedge mclk_i);
        ev[i] <= 1'b0;
    endtask : pulse

    // readback of a mask: unimplemented bits and device-mode attach enable read zero
    function logic [31:0] rbk(input logic [7:0] a, input logic [31:0] v, input logic h);
        rbk = (a == OTG_MASK_OFS) ? (v & OTG_IMPL_MASK) : (v & (h ? 8'hff : DEV_READ_MASK));
    endfunction : rbk

    task results;
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        results();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a <= 16; a += 4) begin
            rdr(a[7:0]);
            chk("reset value", rv, 32'h0);
        end
        rdr(8'h14);
        chk("unmapped resp", rs, RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(CTRL_OFS, {31'h0, i[0]});
            wr(OTG_MASK_OFS, d);
            rdr(OTG_MASK_OFS);
            chk("otg mask", rv, rbk(OTG_MASK_OFS, d, i[0]));
            wr(USB_MASK_OFS, d);
            rdr(USB_MASK_OFS);
            chk("usb mask", rv, rbk(USB_MASK_OFS, d, i[0]));
        end
        wr(CTRL_OFS, 32'h0);
        wr(USB_MASK_OFS, 32'h80);
        wr(USB_FLAGS_OFS, 32'hff);
        pulse(3);
        repeat (2) @(posedge mclk_i);
        chk("irq on stall", irq_o, 1'b1);
        wr(USB_FLAGS_OFS, 32'h7f);
        rdr(USB_FLAGS_OFS);
        chk("stall kept", rv[7], 1'b1);
        fork
            wr(USB_FLAGS_OFS, 32'h80);
            @(posedge mclk_i) pulse(3);
        join
        rdr(USB_FLAGS_OFS);
        chk("set beats clear", rv[7], 1'b1);
        wr(USB_FLAGS_OFS, 32'h80);
        repeat (2) @(posedge mclk_i);
        chk("irq cleared", irq_o, 1'b0);
        ce_i <= 1'b0;
        pulse(3);
        ce_i <= 1'b1;
        rdr(USB_FLAGS_OFS);
        chk("frozen stall", rv[7], 1'b0);
        pulse(2);
        pulse(1);
        rdr(USB_FLAGS_OFS);
        chk("token and sof", rv[3:2], 2'h3);
        n = adv;
        wr(USB_FLAGS_OFS, 32'h08);
        wr(USB_FLAGS_OFS, 32'h08);
        repeat (2) @(posedge mclk_i);
        chk("fifo advance", adv - n, 1);
        unmasked_error_i <= 1'b1;
        wr(USB_FLAGS_OFS, 32'h03);
        rdr(USB_FLAGS_OFS);
        chk("error summary", rv[1:0], 2'h2);
        unmasked_error_i <= 1'b0;
        repeat (60) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("reset once", rv[0], 1'b0);
        dminus_i <= 1'b1;
        repeat (40) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("resume early", rv[5], 1'b0);
        repeat (20) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("resume", rv[5], 1'b1);
        dminus_i <= 1'b0;
        repeat (60) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("bus reset", rv[0], 1'b1);
        dplus_i <= 1'b1;
        repeat (30) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("idle", rv[4], 1'b1);
        wr(OTG_FLAGS_OFS, 32'hff);
        otg_in[3] <= 1'b1;
        rdr(OTG_FLAGS_OFS);
        chk("otg in device", rv[7], 1'b0);
        wr(CTRL_OFS, 32'h1);
        wr(OTG_MASK_OFS, 32'h80);
        wr(USB_MASK_OFS, 32'h0);
        for (int b = 0; b < 8; b++) begin
            wr(OTG_FLAGS_OFS, 32'hff);
            otg_in[b % 4] <= ~otg_in[b % 4];
            rdr(OTG_FLAGS_OFS);
            chk("otg crossing", rv[pos[b % 4]], 1'b1);
            if (b % 4 == 3) chk("otg irq", irq_o, 1'b1);
        end
        rdr(USB_FLAGS_OFS);
        chk("attach", rv[6], 1'b1);
        wr(OTG_MASK_OFS, 32'h0);
        wr(USB_MASK_OFS, 32'h1);
        wr(USB_FLAGS_OFS, 32'hff);
        dplus_i <= 1'b0;
        repeat (40) @(posedge mclk_i);
        chk("detach early", irq_o, 1'b0);
        repeat (20) @(posedge mclk_i);
        chk("detach irq", irq_o, 1'b1);
        wr(CTRL_OFS, 32'h2);
        wr(USB_FLAGS_OFS, 32'hff);
        dplus_i <= 1'b1;
        repeat (60) @(posedge mclk_i);
        rdr(USB_FLAGS_OFS);
        chk("low speed resume", rv[5], 1'b1);
        results();
    end
endmodule : test_uif_usb_irq
`default_nettype wire
